/* design/mcx_pkg.sv */
`default_nettype none
package mcx_pkg;
  // one instruction cycle is four system clocks (20 MHz clk, 200 ns cycle)
  localparam int unsigned CLKS_PER_CYC = 4;
  // byte addresses on the register bus
  localparam logic [8:0] A_INSTR  = 9'h000;
  localparam logic [8:0] A_STATUS = 9'h004;
  localparam logic [8:0] A_WREG   = 9'h008;
  localparam logic [8:0] A_TBLHI  = 9'h00C;
  localparam logic [8:0] A_PC     = 9'h010;
  localparam logic [8:0] A_WDCNT  = 9'h014;
  localparam logic [8:0] A_TWORD  = 9'h018;
  localparam logic [8:0] A_DMEM   = 9'h100;
  // instruction word fields
  localparam int unsigned F_OP   = 0;
  localparam int unsigned F_MADR = 8;
  localparam int unsigned F_IMM  = 16;
  localparam int unsigned F_BIT  = 24;
  localparam int unsigned F_JADR = 16;
  localparam int unsigned F_DSTM = 27;
  localparam int unsigned F_USEI = 28;
  // status register bit positions
  localparam int unsigned S_CARRY = 0;
  localparam int unsigned S_HALF  = 1;
  localparam int unsigned S_NULL  = 2;
  localparam int unsigned S_WRAP  = 3;
  localparam int unsigned S_SLEEP = 4;
  localparam int unsigned S_EXPD  = 5;
  localparam int unsigned S_BUSY  = 6;
  localparam int unsigned S_HALT  = 7;
  localparam int unsigned S_SKIP  = 8;
  // data memory byte that aliases the low program counter
  localparam logic [5:0] PCLOW_ADDR = 6'h06;
  localparam logic [9:0] PC_RST     = 10'h000;
  localparam logic [1:0] DIV_LAST   = 2'(CLKS_PER_CYC - 1);
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DECADJ,
    OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC,
    OP_RR, OP_RL, OP_RRC, OP_RLC, OP_MOVA, OP_MOVM, OP_MOVI,
    OP_CLRB, OP_SETB, OP_JMP, OP_TSTSKIP, OP_TSTCOPY, OP_BZSKIP,
    OP_BNZSKIP, OP_INCSKIP, OP_DECSKIP, OP_CALL, OP_RET, OP_IRET,
    OP_RETI8, OP_TRD_CUR, OP_TRD_LAST, OP_CLRM, OP_SETM,
    OP_WDCLR, OP_WDPRE1, OP_WDPRE2, OP_SWAP, OP_HALT
  } mcx_op_t;
endpackage
`default_nettype wire

/* design/mcx_alu_if.sv */
`default_nettype none
interface mcx_alu_if;
  import mcx_pkg::*;
  mcx_op_t    op;
  logic [7:0] acc;
  logic [7:0] opd;
  logic [2:0] bidx;
  logic       cin;
  logic       hbin;
  logic [7:0] res;
  logic       cout;
  logic       hbout;
  logic       wrapout;
  modport core (output op, acc, opd, bidx, cin, hbin, input res, cout, hbout, wrapout);
  modport alu  (input op, acc, opd, bidx, cin, hbin, output res, cout, hbout, wrapout);
endinterface
`default_nettype wire

/* design/mcx_alu.sv */
`default_nettype none
module mcx_alu (
  mcx_alu_if.alu a
);
  import mcx_pkg::*;
  wire        sub_w = (a.op == OP_SUB) || (a.op == OP_SBC);
  wire [7:0]  b_w   = sub_w ? ~a.opd : a.opd;
  wire        ci_w  = (a.op == OP_ADD) ? 1'b0 : (a.op == OP_SUB) ? 1'b1 : a.cin;
  wire [8:0]  sum_w = {1'b0, a.acc} + {1'b0, b_w} + {8'h00, ci_w};
  wire [4:0]  half_w = {1'b0, a.acc[3:0]} + {1'b0, b_w[3:0]} + {4'h0, ci_w};
  // decimal adjust: low nibble first, its carry feeds the high nibble test
  wire        lo_adj = (a.acc[3:0] > 4'h9) || a.hbin;
  wire [8:0]  t_w    = {1'b0, a.acc} + (lo_adj ? 9'h006 : 9'h000);
  wire        hi_adj = (t_w[7:4] > 4'h9) || a.cin || t_w[8];
  wire [8:0]  d_w    = {1'b0, t_w[7:0]} + (hi_adj ? 9'h060 : 9'h000);
  wire [7:0]  bmask  = 8'h01 << a.bidx;
  always_comb begin
    a.res     = a.opd;
    a.cout    = a.cin;
    a.hbout   = a.hbin;
    a.wrapout = 1'b0;
    case (a.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        a.res     = sum_w[7:0];
        a.cout    = sum_w[8];
        a.hbout   = half_w[4];
        a.wrapout = (a.acc[7] == b_w[7]) && (sum_w[7] != a.acc[7]);
      end
      OP_DECADJ: begin
        a.res  = d_w[7:0];
        a.cout = a.cin | t_w[8] | d_w[8];
      end
      OP_AND:                 a.res = a.acc & a.opd;
      OP_OR:                  a.res = a.acc | a.opd;
      OP_XOR:                 a.res = a.acc ^ a.opd;
      OP_CPL:                 a.res = ~a.opd;
      OP_INC, OP_INCSKIP:     a.res = a.opd + 8'h01;
      OP_DEC, OP_DECSKIP:     a.res = a.opd - 8'h01;
      OP_RR:                  a.res = {a.opd[0], a.opd[7:1]};
      OP_RL:                  a.res = {a.opd[6:0], a.opd[7]};
      OP_RRC: begin
        a.res  = {a.cin, a.opd[7:1]};
        a.cout = a.opd[0];
      end
      OP_RLC: begin
        a.res  = {a.opd[6:0], a.cin};
        a.cout = a.opd[7];
      end
      OP_SWAP:                a.res = {a.opd[3:0], a.opd[7:4]};
      OP_CLRB:                a.res = a.opd & ~bmask;
      OP_SETB:                a.res = a.opd | bmask;
      OP_CLRM:                a.res = 8'h00;
      OP_SETM:                a.res = 8'hFF;
      OP_MOVM:                a.res = a.acc;
      default:                a.res = a.opd;
    endcase
  end
endmodule
`default_nettype wire

/* design/mcx_wdt.sv */
`default_nettype none
module mcx_wdt #(
  parameter int unsigned PRE_W = 8,
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             clr,
  output logic [CNT_W-1:0]      cnt_q,
  output logic                  ovf
);
  logic [PRE_W-1:0] pre_q;
  wire pre_full = &pre_q;
  // raw overflow, even with a clear in the same tick, so the flag logic lets the set win
  assign ovf = tick && pre_full && (&cnt_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (tick) begin
      pre_q <= pre_q + 1'b1;
      if (pre_full) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  chk_clear_zeroes: assert property (@(posedge clk) disable iff (!rst_n)
    clr |=> (cnt_q == '0) && (pre_q == '0))
    else $error("watchdog not zero after clear");
endmodule
`default_nettype wire

/* design/mcx_core.sv */
// Overview of operation
// - additions take one cycle, update null, carry, half-borrow, signed-wrap flags
// - subtractions, borrow-in forms too, take one cycle, update the same four flags
// - decimal adjust writes adjusted working register to memory, one cycle, carry only
// - and, or, xor take one cycle and change only the null flag
// - complement to memory or working register, one cycle, null flag only
// - increment and decrement take one cycle, null flag only
// - plain rotates take one cycle and leave all flags alone
// - rotates through carry form a nine-bit ring, one cycle, carry only
// - moves between memory, working register or immediate, one cycle, no flags
// - immediate operands are eight bits wide
// - bit clear and set address bit 0 to 7, one cycle, no flags
// - jump, call, return, return-with-immediate, interrupt return take two cycles
// - skips test byte null or a bit; the copy form loads working register
// - a taken skip adds one instruction cycle of four clocks
// - writing the low program counter adds one instruction cycle
// - increment/decrement-and-skip to the low program counter get both extra cycles when the result is zero
// - table reads store low byte to memory, upper bits to table high, two cycles
// - nibble swap to memory or working register, one cycle, no flags
// - completed preclear pair clears watchdog, sets expired flag, clears sleep flag
// - a lone preclear leaves expired and sleep flags untouched
// - halt takes one cycle, halts the core, updates expired and sleep flags
// - watchdog clear zeroes counter and prescaler, clears sleep flag, clears expired flag unless a timeout lands in that cycle
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
module mcx_core #(
  parameter int unsigned STK_DEPTH = 4,
  parameter int unsigned DM_WORDS  = 64
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [8:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_q,
  output logic             halted_q
);
  import mcx_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0]  dmem [DM_WORDS];
  logic [9:0]  stk_q [STK_DEPTH];
  logic [1:0]  sp_q;
  logic [9:0]  pc_q;
  logic [7:0]  working_register_q;
  logic [5:0]  table_high_byte_q;
  logic [13:0] tword_q;
  logic        carry_q;
  logic        half_borrow_q;
  logic        null_q;
  logic        signed_wrap_q;
  logic        sleep_entered_q;
  logic        watchdog_expired_q;
  logic        skip_q;
  logic        pre1_q;
  logic        pre2_q;
  logic [1:0]  div_q;
  logic [1:0]  cnt_q;
  logic [31:0] dat_q;
  logic [7:0]  wd_cnt;
  logic        wd_ovf;

  // bus decode; a write lands on the edge where the master sees ack
  wire         bus_req = wb_cyc_i & wb_stb_i;
  wire         wr_go   = bus_req & wb_we_i & wb_ack_o;
  wire [31:0]  wmask;
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
  end
  wire [31:0]  wdat    = wb_dat_i & wmask;
  wire         sel_ins = wb_adr_i == A_INSTR;
  wire         sel_st  = wb_adr_i == A_STATUS;
  wire         sel_wr  = wb_adr_i == A_WREG;
  wire         sel_tw  = wb_adr_i == A_TWORD;
  wire         sel_dm  = wb_adr_i[8] == A_DMEM[8];
  wire [5:0]   dm_idx  = wb_adr_i[7:2];
  // instructions offered while busy or halted are dropped
  wire         issue   = wr_go & sel_ins & ~busy_q & ~halted_q;

  // instruction fields
  wire mcx_op_t op_w   = mcx_op_t'(wdat[F_OP +: 6]);
  wire [5:0]   madr_w  = wdat[F_MADR +: 6];
  wire [7:0]   imm_w   = wdat[F_IMM +: 8];
  wire [2:0]   bidx_w  = wdat[F_BIT +: 3];
  wire [9:0]   jadr_w  = wdat[F_JADR +: 10];
  wire         dstm_w  = wdat[F_DSTM];
  wire         imm_sel = wdat[F_USEI] | (op_w == OP_MOVI) | (op_w == OP_RETI8);
  // the low program counter is visible as a data byte
  wire [7:0]   mem_rd  = (madr_w == PCLOW_ADDR) ? pc_q[7:0] : dmem[madr_w];

  mcx_alu_if ai ();
  assign ai.op   = op_w;
  assign ai.acc  = working_register_q;
  assign ai.opd  = imm_sel ? imm_w : mem_rd;
  assign ai.bidx = bidx_w;
  assign ai.cin  = carry_q;
  assign ai.hbin = half_borrow_q;
  mcx_alu u_alu (
    .a (ai.alu)
  );

  // flag classes
  wire is_arith = op_w inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC};
  wire is_zonly = op_w inside {OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC};
  wire is_crot  = op_w inside {OP_RRC, OP_RLC};
  wire is_dsel  = op_w inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_CPL,
                               OP_INC, OP_DEC, OP_RR, OP_RL, OP_RRC, OP_RLC, OP_SWAP,
                               OP_INCSKIP, OP_DECSKIP};
  wire is_mem   = op_w inside {OP_DECADJ, OP_MOVM, OP_CLRB, OP_SETB, OP_CLRM, OP_SETM};
  wire is_tab   = op_w inside {OP_TRD_CUR, OP_TRD_LAST};
  wire is_two   = op_w inside {OP_JMP, OP_CALL, OP_RET, OP_RETI8, OP_IRET, OP_TRD_CUR, OP_TRD_LAST};
  wire is_ret   = op_w inside {OP_RET, OP_RETI8, OP_IRET};
  wire wr_mem_w = is_mem | is_tab | (is_dsel & dstm_w & ~imm_sel);
  wire wr_acc_w = (is_dsel & ~wr_mem_w) | (op_w inside {OP_MOVA, OP_MOVI, OP_TSTCOPY, OP_RETI8});
  wire [7:0] wval_w = is_tab ? tword_q[7:0] : ai.res;
  wire pcl_w    = wr_mem_w & (madr_w == PCLOW_ADDR);
  wire skip_w   = ((op_w inside {OP_TSTSKIP, OP_TSTCOPY}) & (mem_rd == 8'h00))
                | ((op_w == OP_BZSKIP) & ~mem_rd[bidx_w])
                | ((op_w == OP_BNZSKIP) & mem_rd[bidx_w])
                | ((op_w inside {OP_INCSKIP, OP_DECSKIP}) & (ai.res == 8'h00));
  // base count plus the two independent penalties
  wire [1:0] ncyc_w = (is_two ? 2'd2 : 2'd1) + {1'b0, pcl_w} + {1'b0, skip_w};
  wire pair_hit = ((op_w == OP_WDPRE1) & pre2_q) | ((op_w == OP_WDPRE2) & pre1_q);
  wire wd_clr   = issue & ((op_w inside {OP_WDCLR, OP_HALT}) | pair_hit);
  wire cyc_en   = div_q == DIV_LAST;

  // next program counter
  wire [9:0] pc_inc = pc_q + 10'd1;
  wire [9:0] stk_top = stk_q[2'(sp_q - 2'd1)];
  wire [9:0] pc_nxt = (op_w inside {OP_JMP, OP_CALL}) ? jadr_w
                    : is_ret  ? stk_top
                    : pcl_w   ? {pc_q[9:8], wval_w}
                    : skip_w  ? pc_q + 10'd2
                    : pc_inc;

  mcx_wdt u_wdt (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (cyc_en),
    .clr   (wd_clr),
    .cnt_q (wd_cnt),
    .ovf   (wd_ovf)
  );

  // read mux
  wire [31:0] status_w = {23'h0, skip_q, halted_q, busy_q, watchdog_expired_q, sleep_entered_q,
                          signed_wrap_q, null_q, half_borrow_q, carry_q};
  wire [31:0] rd_w = sel_st ? status_w
                   : sel_wr ? {24'h0, working_register_q}
                   : (wb_adr_i == A_TBLHI) ? {26'h0, table_high_byte_q}
                   : (wb_adr_i == A_PC)    ? {22'h0, pc_q}
                   : (wb_adr_i == A_WDCNT) ? {24'h0, wd_cnt}
                   : sel_tw ? {18'h0, tword_q}
                   : sel_dm ? {24'h0, dmem[dm_idx]}
                   : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      dat_q    <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      dat_q    <= rd_w;
    end
  end
  assign wb_dat_o = dat_q;

  // instruction-cycle divider restarts with every issue so timing is exact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 2'd0;
      busy_q <= 1'b0;
      cnt_q  <= 2'd0;
    end else if (issue) begin
      div_q  <= 2'd0;
      busy_q <= 1'b1;
      cnt_q  <= ncyc_w;
    end else begin
      div_q <= div_q + 2'd1;
      if (busy_q && cyc_en) begin
        cnt_q <= cnt_q - 2'd1;
        busy_q <= cnt_q != 2'd1;
      end
    end
  end

  // arithmetic flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_q       <= 1'b0;
      half_borrow_q <= 1'b0;
      null_q        <= 1'b0;
      signed_wrap_q <= 1'b0;
      skip_q        <= 1'b0;
    end else if (issue) begin
      skip_q <= skip_w;
      if (is_arith | is_crot | (op_w == OP_DECADJ)) begin
        carry_q <= ai.cout;
      end
      if (is_arith) begin
        half_borrow_q <= ai.hbout;
        signed_wrap_q <= ai.wrapout;
      end
      if (is_arith | is_zonly) begin
        null_q <= ai.res == 8'h00;
      end
    end
  end

  // watchdog flags; a timeout in the same cycle as a clear still sets expired
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_expired_q <= 1'b0;
      sleep_entered_q    <= 1'b0;
      pre1_q             <= 1'b0;
      pre2_q             <= 1'b0;
      halted_q           <= 1'b0;
    end else begin
      if (issue && (op_w == OP_WDCLR)) begin
        watchdog_expired_q <= wd_ovf;
        sleep_entered_q    <= 1'b0;
      end else if (issue && pair_hit) begin
        watchdog_expired_q <= 1'b1;
        sleep_entered_q    <= 1'b0;
      end else if (issue && (op_w == OP_HALT)) begin
        watchdog_expired_q <= wd_ovf;
        sleep_entered_q    <= 1'b1;
      end else if (wd_ovf) begin
        watchdog_expired_q <= 1'b1;
      end
      if (issue && (op_w inside {OP_WDPRE1, OP_WDPRE2, OP_WDCLR})) begin
        pre1_q <= (op_w == OP_WDPRE1) & ~pair_hit;
        pre2_q <= (op_w == OP_WDPRE2) & ~pair_hit;
      end
      if (issue && (op_w == OP_HALT)) begin
        halted_q <= 1'b1;
      end else if (wd_ovf || (wr_go && sel_st && wdat[S_HALT])) begin
        halted_q <= 1'b0;
      end
    end
  end

  // program counter, stack and working register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q               <= PC_RST;
      sp_q               <= 2'd0;
      working_register_q <= 8'h00;
      table_high_byte_q  <= 6'h00;
      tword_q            <= 14'h0000;
    end else if (issue) begin
      pc_q <= pc_nxt;
      if (op_w == OP_CALL) begin
        sp_q <= sp_q + 2'd1;
      end else if (is_ret) begin
        sp_q <= sp_q - 2'd1;
      end
      if (wr_acc_w) begin
        working_register_q <= ai.res;
      end
      if (is_tab) begin
        table_high_byte_q <= tword_q[13:8];
      end
    end else begin
      if (wr_go && sel_wr) begin
        working_register_q <= wdat[7:0];
      end
      if (wr_go && sel_tw) begin
        tword_q <= wdat[13:0];
      end
    end
  end

  // storage without reset: contents are undefined until written
  always_ff @(posedge clk) begin
    if (issue && (op_w == OP_CALL)) begin
      stk_q[sp_q] <= pc_inc;
    end
    if (issue && wr_mem_w && !pcl_w) begin
      dmem[madr_w] <= wval_w;
    end else if (wr_go && sel_dm) begin
      dmem[dm_idx] <= wdat[7:0];
    end
  end

  // helper: clocks spent busy per instruction
  logic [3:0] run_q;
  logic [1:0] nlat_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q  <= 4'd0;
      nlat_q <= 2'd0;
    end else if (issue) begin
      run_q  <= 4'd0;
      nlat_q <= ncyc_w;
    end else if (busy_q) begin
      run_q <= run_q + 4'd1;
    end
  end

  chk_busy_length: assert property ($fell(busy_q) |-> run_q == {nlat_q, 2'b00})
    else $error("busy length not four clocks per cycle");
  chk_arith_one: assert property (issue && is_arith && !pcl_w |=> busy_q [*4] ##1 !busy_q)
    else $error("arithmetic did not take one cycle");
  chk_branch_two: assert property (issue && (op_w inside {OP_JMP, OP_CALL, OP_RET})
    |=> busy_q [*8] ##1 !busy_q)
    else $error("branch did not take two cycles");
  chk_skip_taken: assert property (issue && (op_w == OP_TSTSKIP) && (mem_rd == 8'h00)
    |=> (pc_q == $past(pc_q) + 10'd2) ##0 busy_q [*8])
    else $error("taken skip wrong");
  chk_pclow_extra: assert property (issue && (op_w == OP_MOVM) && (madr_w == PCLOW_ADDR)
    |=> pc_q[7:0] == $past(working_register_q) ##0 busy_q [*8] ##1 !busy_q)
    else $error("low pc write penalty wrong");
  chk_both_penalty: assert property (issue && pcl_w && skip_w && (op_w == OP_INCSKIP)
    |=> busy_q [*8] ##1 busy_q [*4] ##1 !busy_q)
    else $error("double penalty missing");
  chk_logic_flags: assert property (issue && (op_w inside {OP_AND, OP_OR, OP_XOR})
    |=> $stable({carry_q, half_borrow_q, signed_wrap_q}) && (null_q == (working_register_q == 8'h00)
    || $past(wr_mem_w)))
    else $error("logic op touched other flags");
  chk_rotate_none: assert property (issue && (op_w inside {OP_RR, OP_RL, OP_SWAP, OP_NOP})
    |=> $stable({carry_q, half_borrow_q, null_q, signed_wrap_q}))
    else $error("plain op changed a flag");
  chk_preclear_hit: assert property (issue && pair_hit |=> watchdog_expired_q && !sleep_entered_q)
    else $error("preclear pair flags wrong");
  chk_preclear_keep: assert property (issue && (op_w inside {OP_WDPRE1, OP_WDPRE2}) && !pair_hit
    && !wd_ovf |=> $stable({watchdog_expired_q, sleep_entered_q}))
    else $error("lone preclear changed flags");
  chk_halt_enter: assert property (issue && (op_w == OP_HALT) |=> halted_q && sleep_entered_q)
    else $error("halt not entered");
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mcx_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [8:0]  adr = 9'h000;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dout;
  logic        ack;
  logic        busy_q;
  logic        halted_q;
  int          n_errors = 0;
  int          check_count = 0;

  always #25 clk = ~clk;

  mcx_core dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .busy_q(busy_q), .halted_q(halted_q));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // one edge passes first so a released strobe is never raised in the same step
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      report_and_stop();
    end
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rc(input string nm, input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    chk(nm, e, q & m);
  endtask

  function automatic logic [8:0] dm(input int i);
    return A_DMEM + 9'(4 * i);
  endfunction

  // issues one instruction and measures how long busy stays up
  task automatic ex(input mcx_op_t op, input int m, input int imm, input int b, input logic d, input logic u,
                    input int n);
    logic [31:0] w;
    logic [31:0] q;
    int          k;
    int          c;
    w = 32'(op) | (32'(m) << F_MADR) | (32'(imm) << F_IMM) | (32'(b) << F_BIT) | (32'(d) << F_DSTM)
        | (32'(u) << F_USEI);
    wb(1'b1, A_INSTR, w, q);
    c = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (busy_q === 1'b1) c++;
      else if (c > 0) break;
    end
    chk("busy clocks", 32'(CLKS_PER_CYC * n), 32'(c));
  endtask

  task automatic t_reset;
    rc("status", A_STATUS, 32'hFFFFFFFF, 32'h0);
    rc("wreg", A_WREG, 32'hFFFFFFFF, 32'h0);
    rc("pc", A_PC, 32'hFFFFFFFF, 32'h0);
    wr(9'h020, 32'h000000A5);
    rc("unmapped", 9'h020, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_arith;
    wr(A_WREG, 32'h7F);
    wr(dm(3), 32'h02);
    ex(OP_ADD, 3, 0, 0, 1'b0, 1'b0, 1);
    rc("add res", A_WREG, 32'hFF, 32'h81);
    rc("add flags", A_STATUS, 32'hF, 32'hA);
    ex(OP_SUB, 0, 8'h81, 0, 1'b0, 1'b1, 1);
    rc("sub res", A_WREG, 32'hFF, 32'h00);
    rc("sub flags", A_STATUS, 32'hD, 32'h5);
    ex(OP_OR, 0, 8'h5A, 0, 1'b0, 1'b1, 1);
    rc("or flags", A_STATUS, 32'hD, 32'h1);
    ex(OP_RR, 3, 0, 0, 1'b0, 1'b0, 1);
    rc("rr res", A_WREG, 32'hFF, 32'h01);
    ex(OP_RRC, 3, 0, 0, 1'b1, 1'b0, 1);
    rc("rrc res", dm(3), 32'hFF, 32'h81);
    rc("rrc flags", A_STATUS, 32'hD, 32'h0);
    wr(A_WREG, 32'h9A);
    ex(OP_DECADJ, 4, 0, 0, 1'b1, 1'b0, 1);
    rc("adj res", dm(4), 32'hFF, 32'h00);
    rc("adj flags", A_STATUS, 32'hD, 32'h1);
    $display("test arith done");
  endtask

  // opcodes the other scenarios leave out; flags end as carry only
  task automatic t_more;
    ex(OP_ADC, 0, 8'h65, 0, 1'b0, 1'b1, 1);
    rc("adc flags", A_STATUS, 32'hF, 32'h7);
    ex(OP_SBC, 3, 0, 0, 1'b1, 1'b0, 1);
    rc("sbc res", dm(3), 32'hFF, 32'h7F);
    rc("sbc flags", A_STATUS, 32'hF, 32'h0);
    ex(OP_XOR, 0, 8'hFF, 0, 1'b0, 1'b1, 1);
    ex(OP_CPL, 3, 0, 0, 1'b0, 1'b0, 1);
    rc("cpl res", A_WREG, 32'hFF, 32'h80);
    ex(OP_INC, 4, 0, 0, 1'b1, 1'b0, 1);
    ex(OP_DEC, 4, 0, 0, 1'b1, 1'b0, 1);
    rc("dec flags", A_STATUS, 32'hF, 32'h4);
    ex(OP_RL, 3, 0, 0, 1'b1, 1'b0, 1);
    ex(OP_RLC, 3, 0, 0, 1'b0, 1'b0, 1);
    rc("rlc res", A_WREG, 32'hFF, 32'hFC);
    rc("rlc flags", A_STATUS, 32'hF, 32'h5);
    ex(OP_MOVI, 0, 8'hC3, 0, 1'b0, 1'b0, 1);
    ex(OP_SETM, 5, 0, 0, 1'b1, 1'b0, 1);
    ex(OP_AND, 5, 0, 0, 1'b0, 1'b0, 1);
    rc("and res", A_WREG, 32'hFF, 32'hC3);
    wr(dm(7), 32'h01);
    ex(OP_DECSKIP, 7, 0, 0, 1'b1, 1'b0, 2);
    rc("decskip res", dm(7), 32'hFF, 32'h00);
    ex(OP_MOVA, 3, 0, 0, 1'b0, 1'b0, 1);
    rc("mova res", A_WREG, 32'hFF, 32'hFE);
    $display("test more done");
  endtask

  task automatic t_bits;
    wr(dm(8), 32'h01);
    ex(OP_SETB, 8, 0, 7, 1'b1, 1'b0, 1);
    ex(OP_CLRB, 8, 0, 0, 1'b1, 1'b0, 1);
    rc("bits", dm(8), 32'hFF, 32'h80);
    ex(OP_SWAP, 8, 0, 0, 1'b0, 1'b0, 1);
    rc("swap", A_WREG, 32'hFF, 32'h08);
    ex(OP_CLRM, 9, 0, 0, 1'b1, 1'b0, 1);
    ex(OP_NOP, 0, 0, 0, 1'b0, 1'b0, 1);
    rc("clr", dm(9), 32'hFF, 32'h00);
    rc("bit flags", A_STATUS, 32'hF, 32'h1);
    $display("test bits done");
  endtask

  // every return pops a pushed address, so the stack is never read unwritten
  task automatic t_branch;
    wr(dm(16), 32'hFF);
    wr(dm(17), 32'h00);
    ex(OP_JMP, 0, 10'h120, 0, 1'b0, 1'b0, 2);
    ex(OP_CALL, 0, 10'h0F0, 0, 1'b0, 1'b0, 2);
    ex(OP_CALL, 0, 10'h0F0, 0, 1'b0, 1'b0, 2);
    ex(OP_CALL, 0, 10'h0F0, 0, 1'b0, 1'b0, 2);
    ex(OP_RET, 0, 0, 0, 1'b0, 1'b0, 2);
    ex(OP_RETI8, 0, 8'h3C, 0, 1'b0, 1'b0, 2);
    rc("ret imm", A_WREG, 32'hFF, 32'h3C);
    ex(OP_IRET, 0, 0, 0, 1'b0, 1'b0, 2);
    rc("ret pc", A_PC, 32'h3FF, 32'h121);
    wr(A_WREG, 32'hFF);
    ex(OP_MOVM, 6, 0, 0, 1'b1, 1'b0, 2);
    rc("pc low", A_PC, 32'h3FF, 32'h1FF);
    ex(OP_INCSKIP, 6, 0, 0, 1'b1, 1'b0, 3);
    ex(OP_INCSKIP, 16, 0, 0, 1'b1, 1'b0, 2);
    ex(OP_INCSKIP, 17, 0, 0, 1'b1, 1'b0, 1);
    ex(OP_TSTSKIP, 16, 0, 0, 1'b0, 1'b0, 2);
    ex(OP_BZSKIP, 8, 0, 7, 1'b0, 1'b0, 1);
    ex(OP_BNZSKIP, 8, 0, 7, 1'b0, 1'b0, 2);
    ex(OP_TSTCOPY, 16, 0, 0, 1'b0, 1'b0, 2);
    rc("copy", A_WREG, 32'hFF, 32'h00);
    rc("br flags", A_STATUS, 32'h10F, 32'h101);
    $display("test branch done");
  endtask

  task automatic t_table;
    wr(A_TWORD, 32'h2A5C);
    ex(OP_TRD_CUR, 10, 0, 0, 1'b1, 1'b0, 2);
    rc("tab lo", dm(10), 32'hFF, 32'h5C);
    rc("tab hi", A_TBLHI, 32'h3F, 32'h2A);
    ex(OP_TRD_LAST, 11, 0, 0, 1'b1, 1'b0, 2);
    rc("tab lo2", dm(11), 32'hFF, 32'h5C);
    $display("test table done");
  endtask

  task automatic t_wdog;
    ex(OP_WDPRE1, 0, 0, 0, 1'b0, 1'b0, 1);
    rc("pre alone", A_STATUS, 32'h30, 32'h00);
    ex(OP_HALT, 0, 0, 0, 1'b0, 1'b0, 1);
    chk("halted", 32'h1, 32'(halted_q));
    rc("halt flags", A_STATUS, 32'h30, 32'h10);
    wr(A_STATUS, 32'h80);
    repeat (2) @(posedge clk);
    chk("woken", 32'h0, 32'(halted_q));
    ex(OP_WDPRE1, 0, 0, 0, 1'b0, 1'b0, 1);
    rc("pre one", A_STATUS, 32'h30, 32'h10);
    ex(OP_WDPRE2, 0, 0, 0, 1'b0, 1'b0, 1);
    rc("pre pair", A_STATUS, 32'h30, 32'h20);
    ex(OP_WDCLR, 0, 0, 0, 1'b0, 1'b0, 1);
    rc("clr flags", A_STATUS, 32'h30, 32'h00);
    rc("wd count", A_WDCNT, 32'hFF, 32'h00);
    $display("test watchdog done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_arith();
    t_more();
    t_bits();
    t_branch();
    t_table();
    t_wdog();
    report_and_stop();
  end
endmodule
`default_nettype wire
